/* File: rtl/clkgen_bank_defines.vh */
// constants for the clock-generator and analog/serial side-band register banks
// assumes an AHB-Lite master with 32-bit data and full 32-bit addresses
`ifndef CLKGEN_BANK_DEFINES_VH
`define CLKGEN_BANK_DEFINES_VH

// ****************************************
// register map
// ****************************************
`define CG_DATA_BASE 32'h50000800
`define CG_RISE_ADDR 32'h50000C10
`define CG_FALL_ADDR 32'h50000C20
`define AS_DATA_BASE 32'h50001000
`define CG_BANK_BASE 32'h50000800
`define AS_BANK_BASE 32'h50001000
`define BANK_SPAN_MSB 10
`define ALIAS_MSB 9

// ****************************************
// clock-generator data byte 0 fields
// ****************************************
`define CG_CP_LSB 0
`define CG_CT_LSB 2
`define CG_POL_BIT 4
`define CG_LOCKED_BIT 5
`define CG_BYPASS_BIT 6
`define CG_IGNORE_BIT 7
`define CG_DATA_RESET 8'h00
`define CG_RW_MASK 8'h9F

// ****************************************
// analog/serial enables fields
// ****************************************
`define AS_BIAS_OFF_BIT 0
`define AS_LNA0_BIT 1
`define AS_LNA1_BIT 2
`define AS_REF0_BIT 3
`define AS_REF1_BIT 4
`define AS_VCM_BIT 5
`define AS_SEA_BIT 6
`define AS_FDA0_BIT 7
`define AS_FDA1_BIT 8
`define AS_CONV_INV_BIT 9
`define AS_BAUD_BIT 16
`define AS_DCD_BIT 17
`define AS_DSR_BIT 18
`define AS_RI_BIT 19
`define AS_IRQ_CFG_BIT 20
`define AS_RING_CFG_BIT 21
`define AS_RESET 32'h00000000
`define AS_RW_MASK 32'h003F03FF
`define IE_RESET 32'h00000000

// ****************************************
// AHB-Lite encodings
// ****************************************
`define HTRANS_NSEQ 2'h2
`define HSIZE_BYTE 3'h0

`endif

/* File: rtl/byte_lane_write.v */
// one byte lane of a register with optional per-bit masked write
// assumes the enables and mask are already decoded in the bus clock domain
module byte_lane_write (
  // lane control
  input wire lane_en,
  input wire masked,
  input wire [7:0] bit_mask,
  // data
  input wire [7:0] old_byte,
  input wire [7:0] new_byte,
  input wire [7:0] writable,
  output wire [7:0] result
);
  wire [7:0] sel;
  // masked byte write keeps unselected bits; wide writes take every writable bit
  assign sel = (lane_en ? (masked ? bit_mask : 8'hFF) : 8'h00) & writable;
  assign result = (new_byte & sel) | (old_byte & ~sel);
endmodule

/* File: rtl/clkgen_analog_banks.v */
// AHB-Lite slave for the clock-generator and analog/serial side-band banks
// assumes the status inputs come from other clock domains or analog cells
`include "clkgen_bank_defines.vh"

// Notes on behaviour
// - lock status bit is read-only, high when the loop is locked
// - bypass status bit is read-only, high when the generator is bypassed
// - lock-override bit tells the clock controller to skip lock on deep-sleep wake
// - charge pump current field resets to 00; software keeps it there
// - oscillator coarse-tune field resets to 00; software keeps it there
// - phase detector invert bit resets low; keep it low
// - per-bit rise and fall enables on data bits raise the bank interrupt
// - bank interrupt is qualified only by the edge enables, no direction gating
// - analog bias disable bit resets low; high kills all bias currents
// - amplifier, reference and common-mode enable outputs reset low, active high
// - converter clock invert bit resets low
// - baud clock enable bit resets low, gates serial baud clock
// - three active-low modem status drives reset low, leaving status asserted
// - byte writes into data windows use address bits 9:2 as bit mask
// - address bits 1:0 select the byte targeted by a masked write
// - half-word and word writes skip the mask and write bytes directly
// - each data register aliases over 1024 bytes from its base
module clkgen_analog_banks (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // clock generator status and control
  input wire pll_locked_in,
  input wire pll_bypassed_in,
  output reg charge_pump_current_0,
  output reg charge_pump_current_1,
  output reg oscillator_coarse_tune_0,
  output reg oscillator_coarse_tune_1,
  output reg phase_detector_invert,
  output reg lock_override,
  output reg clock_gen_irq,
  // analog enables
  output reg analog_bias_disable,
  output reg low_noise_amp0_on,
  output reg low_noise_amp1_on,
  output reg ext_reference0_on,
  output reg ext_reference1_on,
  output reg common_mode_gen_on,
  output reg single_ended_amp_on,
  output reg diff_amp0_on,
  output reg diff_amp1_on,
  output reg converter_clock_invert,
  // serial port side-band
  output reg baud_clock_on,
  output reg ring_indicate_drive_n,
  output reg set_ready_drive_n,
  output reg carrier_detect_drive_n,
  output reg modem_ring_cfg_reserved,
  output reg modem_irq_cfg_reserved
);

  // ****************************************
  // status synchronisers
  // ****************************************
  reg lock_meta_reg;
  reg lock_sync_reg;
  reg byp_meta_reg;
  reg byp_sync_reg;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_meta_reg <= 1'b0;
      lock_sync_reg <= 1'b0;
      byp_meta_reg <= 1'b0;
      byp_sync_reg <= 1'b0;
    end else begin
      lock_meta_reg <= pll_locked_in;
      lock_sync_reg <= lock_meta_reg;
      byp_meta_reg <= pll_bypassed_in;
      byp_sync_reg <= byp_meta_reg;
    end
  end

  // ****************************************
  // address phase capture
  // ****************************************
  reg wr_pend_reg;
  reg [31:0] wr_addr_reg;
  reg [2:0] wr_size_reg;
  wire addr_phase;
  assign addr_phase = hsel && hready && htrans[1];

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h00000000;
      wr_size_reg <= 3'h0;
    end else if (hready) begin
      wr_pend_reg <= addr_phase && hwrite;
      wr_addr_reg <= haddr;
      wr_size_reg <= hsize;
    end
  end

  // ****************************************
  // decode
  // ****************************************
  // data registers answer across their whole aliased window
  function cg_hit;
    input [31:0] a;
    begin
      cg_hit = ({a[31:`BANK_SPAN_MSB], 10'h000} == `CG_DATA_BASE);
    end
  endfunction
  function as_hit;
    input [31:0] a;
    begin
      as_hit = ({a[31:`BANK_SPAN_MSB], 10'h000} == `AS_DATA_BASE);
    end
  endfunction
  function bank_hit;
    input [31:0] a;
    begin
      bank_hit = ({a[31:11], 11'h000} == `CG_BANK_BASE) || ({a[31:11], 11'h000} == `AS_BANK_BASE);
    end
  endfunction

  // byte lanes of the write, from size and address low bits
  reg [3:0] lanes;
  always @* begin
    case (wr_size_reg)
      3'h0: lanes = 4'h1 << wr_addr_reg[1:0];
      3'h1: lanes = wr_addr_reg[1] ? 4'hC : 4'h3;
      default: lanes = 4'hF;
    endcase
  end
  wire masked_wr;
  wire [7:0] wr_mask;
  // mask only applies to byte writes into the data windows
  assign masked_wr = (wr_size_reg == `HSIZE_BYTE);
  assign wr_mask = wr_addr_reg[`ALIAS_MSB:2];

  // ****************************************
  // registers
  // ****************************************
  reg [7:0] cg_data_reg;
  reg [31:0] rise_en_reg;
  reg [31:0] fall_en_reg;
  reg [31:0] as_data_reg;
  wire [7:0] cg_next;
  wire [31:0] as_next;
  wire [31:0] rise_next;
  wire [31:0] fall_next;

  wire cg_wr;
  wire as_wr;
  wire rise_wr;
  wire fall_wr;
  assign cg_wr = wr_pend_reg && cg_hit(wr_addr_reg);
  assign as_wr = wr_pend_reg && as_hit(wr_addr_reg);
  assign rise_wr = wr_pend_reg && ({wr_addr_reg[31:2], 2'h0} == `CG_RISE_ADDR);
  assign fall_wr = wr_pend_reg && ({wr_addr_reg[31:2], 2'h0} == `CG_FALL_ADDR);

  // status bits never take write data
  byte_lane_write cg_lane (
    .lane_en(cg_wr && lanes[0]),
    .masked(masked_wr),
    .bit_mask(wr_mask),
    .old_byte(cg_data_reg),
    .new_byte(hwdata[7:0]),
    .writable(`CG_RW_MASK),
    .result(cg_next)
  );

  wire [31:0] as_rw;
  assign as_rw = `AS_RW_MASK;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : lane
      byte_lane_write as_lane (
        .lane_en(as_wr && lanes[g]),
        .masked(masked_wr),
        .bit_mask(wr_mask),
        .old_byte(as_data_reg[8*g+7:8*g]),
        .new_byte(hwdata[8*g+7:8*g]),
        .writable(as_rw[8*g+7:8*g]),
        .result(as_next[8*g+7:8*g])
      );
      byte_lane_write rise_lane (
        .lane_en(rise_wr && lanes[g]),
        .masked(1'b0),
        .bit_mask(8'hFF),
        .old_byte(rise_en_reg[8*g+7:8*g]),
        .new_byte(hwdata[8*g+7:8*g]),
        .writable(8'hFF),
        .result(rise_next[8*g+7:8*g])
      );
      byte_lane_write fall_lane (
        .lane_en(fall_wr && lanes[g]),
        .masked(1'b0),
        .bit_mask(8'hFF),
        .old_byte(fall_en_reg[8*g+7:8*g]),
        .new_byte(hwdata[8*g+7:8*g]),
        .writable(8'hFF),
        .result(fall_next[8*g+7:8*g])
      );
    end
  endgenerate

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cg_data_reg <= `CG_DATA_RESET;
      as_data_reg <= `AS_RESET;
      rise_en_reg <= `IE_RESET;
      fall_en_reg <= `IE_RESET;
    end else begin
      cg_data_reg <= cg_next;
      as_data_reg <= as_next;
      rise_en_reg <= rise_next;
      fall_en_reg <= fall_next;
    end
  end

  // live view of the clock-generator byte, status bits from synchronisers
  wire [7:0] cg_view;
  assign cg_view = {cg_data_reg[7], byp_sync_reg, lock_sync_reg, cg_data_reg[4:0]};

  // ****************************************
  // edge interrupt
  // ****************************************
  // only the edge enables qualify; no direction register exists here
  reg [7:0] cg_prev_reg;
  wire [7:0] rise_ev;
  wire [7:0] fall_ev;
  assign rise_ev = cg_view & ~cg_prev_reg & rise_en_reg[7:0];
  assign fall_ev = ~cg_view & cg_prev_reg & fall_en_reg[7:0];
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cg_prev_reg <= 8'h00;
      clock_gen_irq <= 1'b0;
    end else begin
      cg_prev_reg <= cg_view;
      clock_gen_irq <= |(rise_ev | fall_ev);
    end
  end

  // ****************************************
  // read path and response
  // ****************************************
  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h00000000;
    if (cg_hit(haddr)) begin
      rd_next = {24'h000000, cg_view};
    end else if (as_hit(haddr)) begin
      rd_next = as_data_reg;
    end else if ({haddr[31:2], 2'h0} == `CG_RISE_ADDR) begin
      rd_next = rise_en_reg;
    end else if ({haddr[31:2], 2'h0} == `CG_FALL_ADDR) begin
      rd_next = fall_en_reg;
    end
  end

  // unmapped addresses outside both banks get the two-cycle error
  reg err_pend_reg;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      err_pend_reg <= 1'b0;
    end else if (err_pend_reg) begin
      hreadyout <= 1'b1;
      err_pend_reg <= 1'b0;
    end else if (addr_phase && !bank_hit(haddr)) begin
      hreadyout <= 1'b0;
      hresp <= 1'b1;
      err_pend_reg <= 1'b1;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_phase && !hwrite) begin
        hrdata <= rd_next;
      end
    end
  end

  // ****************************************
  // side-band outputs
  // ****************************************
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      charge_pump_current_0 <= 1'b0;
      charge_pump_current_1 <= 1'b0;
      oscillator_coarse_tune_0 <= 1'b0;
      oscillator_coarse_tune_1 <= 1'b0;
      phase_detector_invert <= 1'b0;
      lock_override <= 1'b0;
      analog_bias_disable <= 1'b0;
      low_noise_amp0_on <= 1'b0;
      low_noise_amp1_on <= 1'b0;
      ext_reference0_on <= 1'b0;
      ext_reference1_on <= 1'b0;
      common_mode_gen_on <= 1'b0;
      single_ended_amp_on <= 1'b0;
      diff_amp0_on <= 1'b0;
      diff_amp1_on <= 1'b0;
      converter_clock_invert <= 1'b0;
      baud_clock_on <= 1'b0;
      ring_indicate_drive_n <= 1'b0;
      set_ready_drive_n <= 1'b0;
      carrier_detect_drive_n <= 1'b0;
      modem_ring_cfg_reserved <= 1'b0;
      modem_irq_cfg_reserved <= 1'b0;
    end else begin
      // one cycle behind the register, so all outputs stay flopped
      charge_pump_current_0 <= cg_data_reg[`CG_CP_LSB];
      charge_pump_current_1 <= cg_data_reg[`CG_CP_LSB+1];
      oscillator_coarse_tune_0 <= cg_data_reg[`CG_CT_LSB];
      oscillator_coarse_tune_1 <= cg_data_reg[`CG_CT_LSB+1];
      phase_detector_invert <= cg_data_reg[`CG_POL_BIT];
      lock_override <= cg_data_reg[`CG_IGNORE_BIT];
      analog_bias_disable <= as_data_reg[`AS_BIAS_OFF_BIT];
      low_noise_amp0_on <= as_data_reg[`AS_LNA0_BIT];
      low_noise_amp1_on <= as_data_reg[`AS_LNA1_BIT];
      ext_reference0_on <= as_data_reg[`AS_REF0_BIT];
      ext_reference1_on <= as_data_reg[`AS_REF1_BIT];
      common_mode_gen_on <= as_data_reg[`AS_VCM_BIT];
      single_ended_amp_on <= as_data_reg[`AS_SEA_BIT];
      diff_amp0_on <= as_data_reg[`AS_FDA0_BIT];
      diff_amp1_on <= as_data_reg[`AS_FDA1_BIT];
      converter_clock_invert <= as_data_reg[`AS_CONV_INV_BIT];
      baud_clock_on <= as_data_reg[`AS_BAUD_BIT];
      ring_indicate_drive_n <= as_data_reg[`AS_RI_BIT];
      set_ready_drive_n <= as_data_reg[`AS_DSR_BIT];
      carrier_detect_drive_n <= as_data_reg[`AS_DCD_BIT];
      modem_ring_cfg_reserved <= as_data_reg[`AS_RING_CFG_BIT];
      modem_irq_cfg_reserved <= as_data_reg[`AS_IRQ_CFG_BIT];
    end
  end

endmodule

/* File: tb/clkgen_banks_checker.sv */
// checker for the clock-generator and analog/serial register banks
// sees only the top module ports; bound from the testbench top file
module clkgen_banks_checker (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // clock generator
  input wire pll_locked_in,
  input wire pll_bypassed_in,
  input wire clock_gen_irq,
  input wire phase_detector_invert,
  input wire lock_override,
  input wire charge_pump_current_0,
  input wire charge_pump_current_1,
  input wire oscillator_coarse_tune_0,
  input wire oscillator_coarse_tune_1,
  // analog and serial side-band
  input wire analog_bias_disable,
  input wire low_noise_amp0_on,
  input wire low_noise_amp1_on,
  input wire ext_reference0_on,
  input wire ext_reference1_on,
  input wire common_mode_gen_on,
  input wire single_ended_amp_on,
  input wire diff_amp0_on,
  input wire diff_amp1_on,
  input wire converter_clock_invert,
  input wire baud_clock_on,
  input wire ring_indicate_drive_n,
  input wire set_ready_drive_n,
  input wire carrier_detect_drive_n,
  input wire modem_ring_cfg_reserved,
  input wire modem_irq_cfg_reserved
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // helper logic
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire ap = hsel && hready && htrans[1];
  wire mapped = haddr[31:11] == 21'h0A0001 || haddr[31:11] == 21'h0A0002;
  wire [31:0] as_vec = {10'h000, modem_ring_cfg_reserved, modem_irq_cfg_reserved, ring_indicate_drive_n,
    set_ready_drive_n, carrier_detect_drive_n, baud_clock_on, 6'h00, converter_clock_invert, diff_amp1_on,
    diff_amp0_on, single_ended_amp_on, common_mode_gen_on, ext_reference1_on, ext_reference0_on,
    low_noise_amp1_on, low_noise_amp0_on, analog_bias_disable};
  wire [7:0] cg_vec = {lock_override, 2'h0, phase_detector_invert, oscillator_coarse_tune_1,
    oscillator_coarse_tune_0, charge_pump_current_1, charge_pump_current_0};
  // saturating ages: status inputs go through a synchroniser, so irq lags them
  reg [2:0] since_in;
  reg [2:0] since_wr;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      // synchronisers restart from zero, so status is young after reset
      since_in <= 3'h0;
      since_wr <= 3'h0;
    end else begin
      since_in <= ($changed(pll_locked_in) || $changed(pll_bypassed_in)) ? 3'h0 : since_in + {2'h0, since_in != 3'h7};
      since_wr <= (ap && hwrite) ? 3'h0 : since_wr + {2'h0, since_wr != 3'h7};
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  reset_pll_a: assert property ($rose(arst_n) |-> cg_vec == 8'h00)
    else $error("clock generator controls not low after reset");
  reset_analog_a: assert property ($rose(arst_n) |-> as_vec[9:0] == 10'h000)
    else $error("analog enables not low after reset");
  reset_serial_a: assert property ($rose(arst_n) |-> as_vec[31:16] == 16'h0000)
    else $error("serial side-band not low after reset");
  ok_resp_a: assert property (ap && mapped |=> hreadyout && !hresp)
    else $error("mapped transfer not answered okay");
  err_resp_a: assert property (ap && !mapped |=> !hreadyout && hresp ##1 hreadyout && hresp)
    else $error("unmapped transfer without two-cycle error");
  read_as_a: assert property (ap && !hwrite && haddr[31:10] == 22'h140004 |=> hrdata == as_vec)
    else $error("enables read differs from outputs");
  read_cg_a: assert property (ap && !hwrite && haddr[31:10] == 22'h140002 |=>
    hrdata[31:8] == 24'h000000 && (hrdata[7:0] & 8'h9F) == cg_vec)
    else $error("clock generator read differs from outputs");
  lock_read_a: assert property (ap && !hwrite && haddr[31:10] == 22'h140002 && since_in == 3'h7 |=>
    hrdata[6:5] == {$past(pll_bypassed_in), $past(pll_locked_in)})
    else $error("status bits differ from inputs");
  irq_cause_a: assert property (clock_gen_irq |->
    (since_in >= 3'h1 && since_in <= 3'h6) || since_wr <= 3'h2)
    else $error("interrupt without a recent status edge or write");
  quiet_hold_a: assert property (since_wr >= 3'h4 |-> $stable(as_vec) && $stable(cg_vec))
    else $error("side-band output moved without a write");
endmodule

/* File: tb/ahb_master_model.sv */
// bus master model facing the register banks
// single master: the bench feeds hreadyout back as hready
module ahb_master_model (
  // clock
  input wire core_clk,
  // slave answer
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // request
  output reg hsel,
  output reg [31:0] haddr,
  output reg [1:0] htrans,
  output reg hwrite,
  output reg [2:0] hsize,
  output reg [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h00000000;
  end
  // one transfer; data held until the slave is ready, idle address inverted
  task xfer(input [31:0] a, input w, input [2:0] sz, input [31:0] d, output [31:0] rd, output rs);
    begin
      @(negedge core_clk);
      hsel = 1'b1;
      haddr = a;
      htrans = 2'h2;
      hwrite = w;
      hsize = sz;
      @(negedge core_clk);
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = ~a;
      hwdata = w ? d : ~hwdata;
      // no local limit: a stuck slave runs into the bench timeout
      while (hreadyout !== 1'b1) begin
        @(negedge core_clk);
      end
      rd = hrdata;
      rs = hresp;
    end
  endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench for the clock-generator and analog/serial banks
// assumes the bank header constants and a single bus master model
`include "clkgen_bank_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // signals
  // ****************************************
  reg core_clk, arst_n, pll_locked_in, pll_bypassed_in;
  wire hsel, hwrite, hreadyout, hresp, clock_gen_irq;
  wire [1:0] htrans;
  wire [2:0] hsize;
  wire [31:0] haddr, hwdata, hrdata;
  wire charge_pump_current_0, charge_pump_current_1, oscillator_coarse_tune_0, oscillator_coarse_tune_1;
  wire phase_detector_invert, lock_override, analog_bias_disable, low_noise_amp0_on, low_noise_amp1_on;
  wire ext_reference0_on, ext_reference1_on, common_mode_gen_on, single_ended_amp_on, diff_amp0_on, diff_amp1_on;
  wire converter_clock_invert, baud_clock_on, ring_indicate_drive_n, set_ready_drive_n, carrier_detect_drive_n;
  wire modem_ring_cfg_reserved, modem_irq_cfg_reserved;
  wire hready = hreadyout;
  integer n_errors = 0, checked = 0, cycles = 0, irq_cnt = 0, i;
  reg [31:0] rd, expv;
  reg rs;
  clkgen_analog_banks clkgen_analog_banks_i (.core_clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pll_locked_in, .pll_bypassed_in, .charge_pump_current_0,
    .charge_pump_current_1, .oscillator_coarse_tune_0, .oscillator_coarse_tune_1, .phase_detector_invert,
    .lock_override, .clock_gen_irq, .analog_bias_disable, .low_noise_amp0_on, .low_noise_amp1_on,
    .ext_reference0_on, .ext_reference1_on, .common_mode_gen_on, .single_ended_amp_on, .diff_amp0_on,
    .diff_amp1_on, .converter_clock_invert, .baud_clock_on, .ring_indicate_drive_n, .set_ready_drive_n,
    .carrier_detect_drive_n, .modem_ring_cfg_reserved, .modem_irq_cfg_reserved);
  ahb_master_model ahb_master_model_i (.core_clk, .hreadyout, .hresp, .hrdata, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata);
  // ****************************************
  // clock, irq count, timeout
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // irq counted mid-cycle, away from the edge that launches it
  always @(negedge core_clk) begin
    if (clock_gen_irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors = n_errors + 1;
      summarize;
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task chk(input string name, input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("ERROR %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task wr(input [31:0] a, input [2:0] sz, input [31:0] d);
    ahb_master_model_i.xfer(a, 1'b1, sz, d, rd, rs);
  endtask
  task rdchk(input string name, input [31:0] a, input [31:0] exp);
    begin
      ahb_master_model_i.xfer(a, 1'b0, 3'h2, 32'h00000000, rd, rs);
      chk(name, rd, exp);
    end
  endtask
  // byte write, mask in address bits 9:2, lane in 1:0
  task bw(input [31:0] base, input [1:0] idx, input [7:0] mask, input [7:0] v);
    wr(base + {22'h000000, mask, idx}, 3'h0, {4{v}});
  endtask
  task tend(input string name);
    $display("test %0s done", name);
  endtask
  task summarize;
    begin
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    arst_n = 1'b0;
    pll_locked_in = 1'b0;
    pll_bypassed_in = 1'b0;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    arst_n = 1'b1;
    rdchk("cg_reset", `CG_DATA_BASE, 32'h00000000);
    rdchk("as_reset", `AS_DATA_BASE + 32'h000003FC, 32'h00000000);
    rdchk("rise_reset", `CG_RISE_ADDR, 32'h00000000);
    tend("reset");
    expv = 32'h00000000;
    for (i = 0; i < 8; i++) begin
      bw(`AS_DATA_BASE, 2'h0, 8'h01 << i, 8'hFF);
      expv[i] = 1'b1;
      rdchk("as_bit", `AS_DATA_BASE + 32'h00000004 * i, expv);
    end
    bw(`AS_DATA_BASE, 2'h0, 8'h08, 8'h00);
    bw(`AS_DATA_BASE, 2'h2, 8'h0F, 8'h0A);
    bw(`AS_DATA_BASE, 2'h1, 8'h03, 8'h02);
    expv = 32'h000A02F7;
    rdchk("as_lanes", `AS_DATA_BASE + 32'h00000200, expv);
    chk("modem", {ring_indicate_drive_n, set_ready_drive_n, carrier_detect_drive_n, baud_clock_on}, 32'hA);
    chk("conv_inv", converter_clock_invert, 32'h1);
    bw(`AS_DATA_BASE, 2'h2, 8'hFF, 8'h01);
    rdchk("as_full", `AS_DATA_BASE, 32'h000102F7);
    tend("masked");
    wr(`AS_DATA_BASE + 32'h00000004, 3'h1, 32'hFFFF0155);
    rdchk("as_half", `AS_DATA_BASE, 32'h00010155);
    wr(`AS_DATA_BASE + 32'h00000006, 3'h1, 32'h000F0000);
    rdchk("as_upper", `AS_DATA_BASE, 32'h000F0155);
    wr(`AS_DATA_BASE + 32'h000003FC, 3'h2, 32'h00000000);
    rdchk("as_word", `AS_DATA_BASE, 32'h00000000);
    tend("wide");
    bw(`CG_DATA_BASE, 2'h0, 8'h7F, 8'hFF);
    rdchk("cg_ro", `CG_DATA_BASE + 32'h00000100, 32'h0000001F);
    pll_locked_in = 1'b1;
    pll_bypassed_in = 1'b1;
    repeat (8) @(negedge core_clk);
    // software sees lock before the override goes on
    rdchk("cg_lock", `CG_DATA_BASE, 32'h0000007F);
    bw(`CG_DATA_BASE, 2'h0, 8'h80, 8'hFF);
    rdchk("cg_status", `CG_DATA_BASE + 32'h00000200, 32'h000000FF);
    chk("override", lock_override, 32'h1);
    chk("irq_idle", irq_cnt, 32'h0);
    bw(`CG_DATA_BASE, 2'h0, 8'hFF, 8'h00);
    pll_locked_in = 1'b0;
    pll_bypassed_in = 1'b0;
    repeat (8) @(negedge core_clk);
    tend("clock_gen");
    wr(`CG_RISE_ADDR, 3'h2, 32'h00000020);
    wr(`CG_FALL_ADDR, 3'h2, 32'h00000040);
    rdchk("rise_en", `CG_RISE_ADDR, 32'h00000020);
    // lock rise, lock fall, bypass rise, bypass fall: only two are enabled
    for (i = 0; i < 4; i++) begin
      expv = irq_cnt + ((i == 0 || i == 3) ? 1 : 0);
      pll_locked_in = (i == 0);
      pll_bypassed_in = (i == 2);
      repeat (10) @(negedge core_clk);
      chk("irq_count", irq_cnt, expv);
    end
    tend("irq");
    bw(`AS_DATA_BASE, 2'h0, 8'hFF, 8'hFF);
    repeat (2) @(negedge core_clk);
    chk("bias_off", analog_bias_disable, 32'h1);
    arst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    arst_n = 1'b1;
    rdchk("as_rst2", `AS_DATA_BASE, 32'h00000000);
    rdchk("rise_rst2", `CG_RISE_ADDR, 32'h00000000);
    chk("amp_rst2", low_noise_amp0_on, 32'h0);
    tend("reset2");
    ahb_master_model_i.xfer(32'h50001800, 1'b0, 3'h2, 32'h00000000, rd, rs);
    chk("err_resp", rs, 32'h1);
    rdchk("reserved", 32'h50000C00, 32'h00000000);
    chk("ok_resp", rs, 32'h0);
    tend("decode");
    summarize;
  end
endmodule
bind clkgen_analog_banks clkgen_banks_checker clkgen_banks_checker_i (.core_clk, .arst_n, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .pll_locked_in, .pll_bypassed_in, .clock_gen_irq,
  .phase_detector_invert, .lock_override, .charge_pump_current_0, .charge_pump_current_1, .oscillator_coarse_tune_0,
  .oscillator_coarse_tune_1, .analog_bias_disable, .low_noise_amp0_on, .low_noise_amp1_on, .ext_reference0_on,
  .ext_reference1_on, .common_mode_gen_on, .single_ended_amp_on, .diff_amp0_on, .diff_amp1_on,
  .converter_clock_invert, .baud_clock_on, .ring_indicate_drive_n, .set_ready_drive_n, .carrier_detect_drive_n,
  .modem_ring_cfg_reserved, .modem_irq_cfg_reserved);
